/* File: inc/dtp_regs.svh */
// timing and field constants for the dual-channel timer bank
// assumes a single 100 MHz system clock
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH

`define DTP_CLK_HZ        32'd100000000
`define DTP_CLK_NS        10
`define DTP_US_NS         1000
`define DTP_CYC_PER_US    (`DTP_US_NS / `DTP_CLK_NS)
`define DTP_DUTY_FULL     14'd10000
`define DTP_WIDTH_NARROW  6'd16
`define DTP_WIDTH_WIDE    6'd32
`define DTP_PRIO_MIN      3'd1
`define DTP_NUM_TIMERS    4
`define DTP_NUM_CHANS     8
`define DTP_NUM_PINS      5
`define DTP_DIV_STEPS     6'd32
`define DTP_RESET_MODE    2'd0
// channel index driving each pwm pin: t0a, t1a, t2b, t3a, t3b
`define DTP_PIN_CHANS     {3'd7, 3'd6, 3'd5, 3'd2, 3'd0}

`endif

/* File: inc/dtp_pkg.sv */
// types shared by the timer bank modules
// assumes dtp_regs.svh supplies the numeric constants
package dtp_pkg;
  typedef enum logic [1:0] {
    DTP_ONE_SHOT = 2'h0,
    DTP_PERIODIC = 2'h1,
    DTP_PWM      = 2'h2
  } dtp_mode_t;

  typedef enum logic [1:0] {
    DTP_SEL_A  = 2'h1,
    DTP_SEL_B  = 2'h2,
    DTP_SEL_AB = 2'h3
  } dtp_sel_t;

  // gray codes along idle -> period -> duty -> commit
  typedef enum logic [1:0] {
    DTP_IDLE   = 2'h0,
    DTP_DIVP   = 2'h1,
    DTP_DIVD   = 2'h3,
    DTP_COMMIT = 2'h2
  } dtp_state_t;
endpackage

/* File: inc/dtp_chan_if.sv */
// control and result signals between the bank controller and one channel
// assumes all signals are synchronous to sys_clk
`timescale 1ns/1ps
interface dtp_chan_if;
  logic               run;
  dtp_pkg::dtp_mode_t mode;
  logic               load;
  logic [31:0]        reload;
  logic [31:0]        compare;
  logic               polNeg;
  logic               evt;
  logic               match;
  logic               pwm;

  modport ctl  (output run, mode, load, reload, compare, polNeg,
                input evt, match, pwm);
  modport chan (input run, mode, load, reload, compare, polNeg,
                output evt, match, pwm);
endinterface

/* File: verilog/dtp_channel.sv */
// one timer channel: counter, period reload, pwm compare and events
// assumes the controller holds run low while the timer is shut down
`timescale 1ns/1ps
module dtp_channel (
  input wire logic sys_clk,
  input wire logic srst,
  dtp_chan_if.chan ch
);
  logic [31:0] cnt_r,    cnt_nxt;
  logic [31:0] rld_r,    rld_nxt;
  logic [31:0] cmp_r,    cmp_nxt;
  logic [31:0] pRld_r,   pRld_nxt;
  logic [31:0] pCmp_r,   pCmp_nxt;
  logic        pPol_r,   pPol_nxt;
  logic        pend_r,   pend_nxt;
  logic        pol_r,    pol_nxt;
  logic        act_r,    act_nxt;
  logic        evt_r,    evt_nxt;
  logic        match_r,  match_nxt;
  logic        pwm_r,    pwm_nxt;
  logic        atEnd;
  logic        isPwm;

  always_comb begin
    cnt_nxt   = cnt_r;
    rld_nxt   = rld_r;
    cmp_nxt   = cmp_r;
    pRld_nxt  = pRld_r;
    pCmp_nxt  = pCmp_r;
    pPol_nxt  = pPol_r;
    pend_nxt  = pend_r;
    pol_nxt   = pol_r;
    act_nxt   = act_r;
    evt_nxt   = 1'b0;
    match_nxt = 1'b0;
    isPwm     = (ch.mode == dtp_pkg::DTP_PWM);
    atEnd     = (cnt_r == rld_r - 32'h1);
    if (!ch.run) begin
      act_nxt  = 1'b0;
      pend_nxt = 1'b0;
      cnt_nxt  = 32'h0;
    end else if (ch.load && !act_r) begin
      rld_nxt = ch.reload;
      cmp_nxt = ch.compare;
      pol_nxt = ch.polNeg;
      cnt_nxt = 32'h0;
      act_nxt = 1'b1;
    end else if (act_r) begin
      if (ch.load) begin
        // new timing waits for the period boundary
        pRld_nxt = ch.reload;
        pCmp_nxt = ch.compare;
        pPol_nxt = ch.polNeg;
        pend_nxt = 1'b1;
      end
      if (isPwm && cnt_r == cmp_r && cmp_r != rld_r) begin
        evt_nxt   = 1'b1;
        match_nxt = 1'b1;
      end
      if (atEnd) begin
        cnt_nxt = 32'h0;
        if (!isPwm) begin
          evt_nxt = 1'b1;
        end
        if (ch.mode == dtp_pkg::DTP_ONE_SHOT) begin
          act_nxt = 1'b0;
        end
        if (pend_r && !ch.load) begin
          rld_nxt  = pRld_r;
          cmp_nxt  = pCmp_r;
          pol_nxt  = pPol_r;
          pend_nxt = 1'b0;
        end
      end else begin
        cnt_nxt = cnt_r + 32'h1;
      end
    end
    // full duty makes compare equal reload, so the level never drops
    pwm_nxt = (act_nxt && isPwm && (cnt_nxt < cmp_nxt)) ^ pol_nxt;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r   <= 32'h0;
      rld_r   <= 32'h0;
      cmp_r   <= 32'h0;
      pRld_r  <= 32'h0;
      pCmp_r  <= 32'h0;
      pPol_r  <= 1'b0;
      pend_r  <= 1'b0;
      pol_r   <= 1'b0;
      act_r   <= 1'b0;
      evt_r   <= 1'b0;
      match_r <= 1'b0;
      pwm_r   <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      rld_r   <= rld_nxt;
      cmp_r   <= cmp_nxt;
      pRld_r  <= pRld_nxt;
      pCmp_r  <= pCmp_nxt;
      pPol_r  <= pPol_nxt;
      pend_r  <= pend_nxt;
      pol_r   <= pol_nxt;
      act_r   <= act_nxt;
      evt_r   <= evt_nxt;
      match_r <= match_nxt;
      pwm_r   <= pwm_nxt;
    end
  end

  assign ch.evt   = evt_r;
  assign ch.match = match_r;
  assign ch.pwm   = pwm_r;
endmodule

/* File: verilog/dtp_top.sv */
// bank of four two-channel timers with pwm pins and prioritised events
// assumes commands are one-cycle pulses, taken only while busy is low
// Function
// - four timers, indexed zero to three
// - two 16-bit channels, chainable to 32
// - single-run counts one period then stops
// - periodic restarts at every period end
// - pwm mode drives waveform onto pin
// - width accepts only sixteen or thirty-two
// - thirty-two bits never in pwm mode
// - shutdown stops channels, events and power
// - polarity sets active level of duty
// - duty 0 to 10000, max always active
// - pins fixed: t0a, t1a, t2b, t3a, t3b
// - periodic raises event every period
// - single-run raises event exactly once
// - pwm raises event at duty compare
// - timeout for counting, match for pwm
// - event priority 1 to 7, higher wins
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_top #(
  parameter int NUM_TIMERS = `DTP_NUM_TIMERS
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        initReq,
  input  wire logic        deinitReq,
  input  wire logic [1:0]  cmdTimer,
  input  wire logic [1:0]  initMode,
  input  wire logic [5:0]  initWidth,
  input  wire logic        chReq,
  input  wire logic [1:0]  chSel,
  input  wire logic        chUseFreq,
  input  wire logic [31:0] chValue,
  input  wire logic [13:0] chDuty,
  input  wire logic        chPolNeg,
  input  wire logic        chIrqEn,
  input  wire logic [2:0]  chPrio,
  output      logic        busy,
  output      logic        cfgErr,
  output      logic [3:0]  timerPowered,
  output      logic [7:0]  chanEvent,
  output      logic [7:0]  chanMatch,
  output      logic        irqValid,
  output      logic [2:0]  irqChan,
  output      logic [2:0]  irqPrio,
  output      logic        irqMatch,
  output      logic [4:0]  pwmPin,
  output      logic [4:0]  pwmPinEn
);
  localparam logic [14:0] PIN_CHANS = `DTP_PIN_CHANS;

  dtp_chan_if chIf [`DTP_NUM_CHANS] ();

  dtp_pkg::dtp_state_t st_r, st_nxt;
  dtp_pkg::dtp_mode_t  mode_r [NUM_TIMERS];
  dtp_pkg::dtp_mode_t  mode_nxt [NUM_TIMERS];
  logic [3:0]  pwr_r,    pwr_nxt;
  logic [3:0]  wide_r,   wide_nxt;
  logic [7:0]  on_r,     on_nxt;
  logic [7:0]  irqEn_r,  irqEn_nxt;
  logic [2:0]  prio_r [`DTP_NUM_CHANS];
  logic [2:0]  prio_nxt [`DTP_NUM_CHANS];
  logic [1:0]  tmr_r,    tmr_nxt;
  logic [1:0]  sel_r,    sel_nxt;
  logic [13:0] duty_r,   duty_nxt;
  logic        pol_r,    pol_nxt;
  logic        ien_r,    ien_nxt;
  logic [2:0]  cprio_r,  cprio_nxt;
  logic [31:0] rld_r,    rld_nxt;
  logic [31:0] quo_r,    quo_nxt;
  logic [32:0] rem_r,    rem_nxt;
  logic [31:0] dvs_r,    dvs_nxt;
  logic [5:0]  step_r,   step_nxt;
  logic        err_r,    err_nxt;
  logic [7:0]  load;
  logic [32:0] remSh;
  logic [63:0] usCyc;
  logic        selOk;
  logic [2:0]  chA;

  // shared restoring divider, one quotient bit per cycle
  always_comb begin
    remSh = {rem_r[31:0], quo_r[31]};
    usCyc = {32'h0, chValue} * 64'(`DTP_CYC_PER_US);
  end

  always_comb begin
    st_nxt    = st_r;
    pwr_nxt   = pwr_r;
    wide_nxt  = wide_r;
    on_nxt    = on_r;
    irqEn_nxt = irqEn_r;
    tmr_nxt   = tmr_r;
    sel_nxt   = sel_r;
    duty_nxt  = duty_r;
    pol_nxt   = pol_r;
    ien_nxt   = ien_r;
    cprio_nxt = cprio_r;
    rld_nxt   = rld_r;
    quo_nxt   = quo_r;
    rem_nxt   = rem_r;
    dvs_nxt   = dvs_r;
    step_nxt  = step_r;
    err_nxt   = 1'b0;
    load      = 8'h0;
    chA       = {cmdTimer, 1'b0};
    for (int i = 0; i < NUM_TIMERS; i++) begin
      mode_nxt[i] = mode_r[i];
    end
    for (int i = 0; i < `DTP_NUM_CHANS; i++) begin
      prio_nxt[i] = prio_r[i];
    end
    selOk = wide_r[cmdTimer] ? (chSel == dtp_pkg::DTP_SEL_AB)
                             : (chSel == dtp_pkg::DTP_SEL_A ||
                                chSel == dtp_pkg::DTP_SEL_B);
    unique case (st_r)
      dtp_pkg::DTP_IDLE: begin
        if (deinitReq) begin
          pwr_nxt[cmdTimer]          = 1'b0;
          on_nxt[chA +: 2]           = 2'b00;
          irqEn_nxt[chA +: 2]        = 2'b00;
        end else if (initReq) begin
          if ((initWidth != `DTP_WIDTH_NARROW &&
               initWidth != `DTP_WIDTH_WIDE) ||
              (initWidth == `DTP_WIDTH_WIDE &&
               initMode == dtp_pkg::DTP_PWM) ||
              initMode == 2'h3) begin
            err_nxt = 1'b1;
          end else begin
            mode_nxt[cmdTimer]  = dtp_pkg::dtp_mode_t'(initMode);
            wide_nxt[cmdTimer]  = (initWidth == `DTP_WIDTH_WIDE);
            pwr_nxt[cmdTimer]   = 1'b1;
            on_nxt[chA +: 2]    = 2'b00;
            irqEn_nxt[chA +: 2] = 2'b00;
          end
        end else if (chReq) begin
          if (!pwr_r[cmdTimer] || !selOk || chValue == 32'h0 ||
              chDuty > `DTP_DUTY_FULL || chPrio < `DTP_PRIO_MIN ||
              (!chUseFreq && usCyc[63:32] != 32'h0)) begin
            err_nxt = 1'b1;
          end else begin
            tmr_nxt   = cmdTimer;
            sel_nxt   = chSel;
            duty_nxt  = chDuty;
            pol_nxt   = chPolNeg;
            ien_nxt   = chIrqEn;
            cprio_nxt = chPrio;
            if (chUseFreq) begin
              // cycles per period = clock rate / frequency
              quo_nxt  = `DTP_CLK_HZ;
              dvs_nxt  = chValue;
              rem_nxt  = 33'h0;
              step_nxt = 6'h0;
              st_nxt   = dtp_pkg::DTP_DIVP;
            end else begin
              rld_nxt  = usCyc[31:0];
              quo_nxt  = rld_nxt * 32'(chDuty);
              dvs_nxt  = 32'(`DTP_DUTY_FULL);
              rem_nxt  = 33'h0;
              step_nxt = 6'h0;
              st_nxt   = dtp_pkg::DTP_DIVD;
            end
          end
        end
      end
      dtp_pkg::DTP_DIVP, dtp_pkg::DTP_DIVD: begin
        if (remSh >= {1'b0, dvs_r}) begin
          rem_nxt = remSh - {1'b0, dvs_r};
          quo_nxt = {quo_r[30:0], 1'b1};
        end else begin
          rem_nxt = remSh;
          quo_nxt = {quo_r[30:0], 1'b0};
        end
        step_nxt = step_r + 6'h1;
        if (step_r == `DTP_DIV_STEPS - 6'h1) begin
          if (st_r == dtp_pkg::DTP_DIVP) begin
            rld_nxt  = quo_nxt;
            quo_nxt  = quo_nxt * 32'(duty_r);
            rem_nxt  = 33'h0;
            dvs_nxt  = 32'(`DTP_DUTY_FULL);
            step_nxt = 6'h0;
            st_nxt   = dtp_pkg::DTP_DIVD;
          end else begin
            st_nxt = dtp_pkg::DTP_COMMIT;
          end
        end
      end
      dtp_pkg::DTP_COMMIT: begin
        st_nxt = dtp_pkg::DTP_IDLE;
        // a narrow channel cannot hold more than 16 bits of count
        if (rld_r == 32'h0 ||
            (!wide_r[tmr_r] && rld_r[31:16] != 16'h0)) begin
          err_nxt = 1'b1;
        end else begin
          for (int c = 0; c < 2; c++) begin
            if (sel_r[c] && !(wide_r[tmr_r] && c == 1)) begin
              load[{tmr_r, 1'(c)}]      = 1'b1;
              on_nxt[{tmr_r, 1'(c)}]    = 1'b1;
              irqEn_nxt[{tmr_r, 1'(c)}] = ien_r;
              prio_nxt[{tmr_r, 1'(c)}]  = cprio_r;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r    <= dtp_pkg::DTP_IDLE;
      pwr_r   <= 4'h0;
      wide_r  <= 4'h0;
      on_r    <= 8'h0;
      irqEn_r <= 8'h0;
      tmr_r   <= 2'h0;
      sel_r   <= 2'h0;
      duty_r  <= 14'h0;
      pol_r   <= 1'b0;
      ien_r   <= 1'b0;
      cprio_r <= 3'h0;
      rld_r   <= 32'h0;
      quo_r   <= 32'h0;
      rem_r   <= 33'h0;
      dvs_r   <= 32'h0;
      step_r  <= 6'h0;
      err_r   <= 1'b0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        mode_r[i] <= dtp_pkg::dtp_mode_t'(`DTP_RESET_MODE);
      end
      for (int i = 0; i < `DTP_NUM_CHANS; i++) begin
        prio_r[i] <= `DTP_PRIO_MIN;
      end
    end else begin
      st_r    <= st_nxt;
      pwr_r   <= pwr_nxt;
      wide_r  <= wide_nxt;
      on_r    <= on_nxt;
      irqEn_r <= irqEn_nxt;
      tmr_r   <= tmr_nxt;
      sel_r   <= sel_nxt;
      duty_r  <= duty_nxt;
      pol_r   <= pol_nxt;
      ien_r   <= ien_nxt;
      cprio_r <= cprio_nxt;
      rld_r   <= rld_nxt;
      quo_r   <= quo_nxt;
      rem_r   <= rem_nxt;
      dvs_r   <= dvs_nxt;
      step_r  <= step_nxt;
      err_r   <= err_nxt;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        mode_r[i] <= mode_nxt[i];
      end
      for (int i = 0; i < `DTP_NUM_CHANS; i++) begin
        prio_r[i] <= prio_nxt[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DTP_NUM_CHANS; g++) begin : gChan
      // the load pulse must see run high, since on_r only rises with it
      assign chIf[g].run     = pwr_r[g / 2] &&
                               (on_r[g] || load[g]);
      assign chIf[g].mode    = mode_r[g / 2];
      assign chIf[g].load    = load[g];
      assign chIf[g].reload  = rld_r;
      assign chIf[g].compare = quo_r;
      assign chIf[g].polNeg  = pol_r;
      assign chanEvent[g]    = chIf[g].evt;
      assign chanMatch[g]    = chIf[g].match;
      dtp_channel uChan (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ch      (chIf[g])
      );
    end
  endgenerate

  // pins are hard-wired to their channels; idle pins are not driven
  logic [7:0] chPwm;
  for (genvar p = 0; p < `DTP_NUM_CHANS; p++) begin : gPwm
    assign chPwm[p] = chIf[p].pwm;
  end
  always_comb begin
    for (int p = 0; p < `DTP_NUM_PINS; p++) begin
      pwmPin[p]   = chPwm[PIN_CHANS[p*3 +: 3]];
      pwmPinEn[p] = on_r[PIN_CHANS[p*3 +: 3]] &&
                    pwr_r[PIN_CHANS[p*3+1 +: 2]] &&
                    mode_r[PIN_CHANS[p*3+1 +: 2]] == dtp_pkg::DTP_PWM;
    end
  end

  // highest priority event wins; a tie goes to the lower channel
  logic       irqV_r, irqV_nxt, irqM_r, irqM_nxt;
  logic [2:0] irqC_r, irqC_nxt, irqP_r, irqP_nxt;
  always_comb begin
    irqV_nxt = 1'b0;
    irqC_nxt = 3'h0;
    irqP_nxt = 3'h0;
    irqM_nxt = 1'b0;
    for (int i = 0; i < `DTP_NUM_CHANS; i++) begin
      if (chanEvent[i] && irqEn_r[i] && on_r[i] &&
          (!irqV_nxt || prio_r[i] > irqP_nxt)) begin
        irqV_nxt = 1'b1;
        irqC_nxt = 3'(i);
        irqP_nxt = prio_r[i];
        irqM_nxt = chanMatch[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irqV_r <= 1'b0;
      irqC_r <= 3'h0;
      irqP_r <= 3'h0;
      irqM_r <= 1'b0;
    end else begin
      irqV_r <= irqV_nxt;
      irqC_r <= irqC_nxt;
      irqP_r <= irqP_nxt;
      irqM_r <= irqM_nxt;
    end
  end

  assign busy         = (st_r != dtp_pkg::DTP_IDLE);
  assign cfgErr       = err_r;
  assign timerPowered = pwr_r;
  assign irqValid     = irqV_r;
  assign irqChan      = irqC_r;
  assign irqPrio      = irqP_r;
  assign irqMatch     = irqM_r;
endmodule

/* File: testbench/dtp_top_monitor.sv */
// port checker for the timer bank top
// assumes it is bound to dtp_top and sees only that module's ports
`timescale 1ns/1ps
module dtp_top_monitor #(
  parameter int NUM_TIMERS = 4
) (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       deinitReq,
  input wire logic [1:0] cmdTimer,
  input wire logic       busy,
  input wire logic [3:0] timerPowered,
  input wire logic [7:0] chanEvent,
  input wire logic [7:0] chanMatch,
  input wire logic       irqValid,
  input wire logic [2:0] irqChan,
  input wire logic [2:0] irqPrio,
  input wire logic       irqMatch,
  input wire logic [4:0] pwmPinEn
);
  logic [7:0] prevEv_r;
  logic [7:0] prevMt_r;
  logic [7:0] busyRun_r;

  // irq trails its event by one cycle, so keep the event vector a cycle
  always_ff @(posedge sys_clk) begin
    prevEv_r  <= srst ? 8'h0 : chanEvent;
    prevMt_r  <= srst ? 8'h0 : chanMatch;
    busyRun_r <= (srst || !busy) ? 8'h0 : busyRun_r + 8'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_irq_src;
    irqValid |-> prevEv_r[irqChan];
  endproperty
  property p_irq_kind;
    irqValid |-> irqMatch == prevMt_r[irqChan];
  endproperty
  property p_prio;
    irqValid |-> irqPrio != 3'h0;
  endproperty
  property p_match_evt;
    chanMatch != 8'h0 |-> (chanMatch & ~chanEvent) == 8'h0;
  endproperty
  property p_pin_pwr;
    pwmPinEn != 5'h0 |-> (pwmPinEn & ~{timerPowered[3],
      timerPowered[3], timerPowered[2:0]}) == 5'h0;
  endproperty
  property p_quiet;
    $fell(timerPowered[0]) |-> ##2 (chanEvent[1:0] == 2'h0)[*8];
  endproperty
  property p_busy;
    $fell(busy) |-> busyRun_r == 8'd33 || busyRun_r == 8'd65;
  endproperty
  property p_deinit_off;
    (deinitReq && !busy) |-> ##1 !timerPowered[$past(cmdTimer)];
  endproperty

  a_irq_src: assert property (p_irq_src)
    else $error("irq without a source event");
  a_irq_kind: assert property (p_irq_kind)
    else $error("irq kind differs from event kind");
  a_prio: assert property (p_prio)
    else $error("irq priority zero");
  a_match_evt: assert property (p_match_evt)
    else $error("match without event");
  a_pin_pwr: assert property (p_pin_pwr)
    else $error("pin driven by unpowered timer");
  a_quiet: assert property (p_quiet)
    else $error("event after shutdown");
  a_busy: assert property (p_busy)
    else $error("busy span wrong length");
  a_deinit_off: assert property (p_deinit_off)
    else $error("timer still powered after shutdown");

  c_match: cover property (irqValid && irqMatch);
  c_down: cover property ($fell(timerPowered[0]));
  c_busy: cover property ($fell(busy));
endmodule

bind dtp_top dtp_top_monitor #(.NUM_TIMERS(NUM_TIMERS)) mon_u (
  .sys_clk(sys_clk), .srst(srst), .deinitReq(deinitReq),
  .cmdTimer(cmdTimer), .busy(busy), .timerPowered(timerPowered),
  .chanEvent(chanEvent), .chanMatch(chanMatch), .irqValid(irqValid),
  .irqChan(irqChan), .irqPrio(irqPrio), .irqMatch(irqMatch),
  .pwmPinEn(pwmPinEn)
);

/* File: testbench/dtp_pin_load.sv */
// model of the pads fed by the five pwm pins
// assumes the pads have no pull resistor
`timescale 1ns/1ps
module dtp_pin_load (
  input  wire logic       sys_clk,
  input  wire logic [4:0] pwmPin,
  input  wire logic [4:0] pwmPinEn,
  output      logic [4:0] padLevel
);
  logic [4:0] lastLvl_r = 5'h0;

  // a released pad shows the inverse of its last driven level
  always_comb padLevel = (pwmPin & pwmPinEn) |
                         (~lastLvl_r & ~pwmPinEn);
  always_ff @(posedge sys_clk) begin
    lastLvl_r <= (pwmPin & pwmPinEn) | (lastLvl_r & ~pwmPinEn);
  end
endmodule

/* File: testbench/test_dual_channel_timer_pwm.sv */
// self-checking bench for the timer bank: commands, events and pwm pins
// assumes the pin model and the port checker are compiled before it
`timescale 1ns/1ps
module test_dual_channel_timer_pwm;
  logic        sys_clk = 1'b0, srst = 1'b1;
  logic        initReq = 1'b0, deinitReq = 1'b0, chReq = 1'b0;
  logic [1:0]  cmdTimer = 2'h0, initMode = 2'h0, chSel = 2'h1;
  logic [5:0]  initWidth = 6'h10;
  logic        chUseFreq = 1'b0, chPolNeg = 1'b0, chIrqEn = 1'b1;
  logic [31:0] chValue = 32'h0;
  logic [13:0] chDuty = 14'h0;
  logic [2:0]  chPrio = 3'h1, irqChan, irqPrio, lastPrio = 3'h0;
  logic [2:0]  lastChan = 3'h0;
  logic        busy, cfgErr, irqValid, irqMatch;
  logic        errSeen = 1'b0, lastKind = 1'b0;
  logic [3:0]  timerPowered;
  logic [7:0]  chanEvent, chanMatch;
  logic [4:0]  pwmPin, pwmPinEn, padLevel;
  int          num_errors = 0, num_checks = 0;
  int          cyc = 0, lastEv0 = 0, gap0 = 0;
  int          evCnt[8], mtCnt[8], hiCnt[5];
  logic [1:0]  badM[3] = '{2'h3, 2'h1, 2'h2};
  logic [5:0]  badW[3] = '{6'h10, 6'h14, 6'h20};
  logic [13:0] dutyT[4] = '{14'd3000, 14'd3020, 14'd10000, 14'd0};
  logic        polT[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int          hiT[4] = '{300, 700, 1000, 0};
  int          mtT[4] = '{10, 10, 0, 10};

  dtp_top dut_u (
    .sys_clk(sys_clk), .srst(srst), .initReq(initReq),
    .deinitReq(deinitReq), .cmdTimer(cmdTimer), .initMode(initMode),
    .initWidth(initWidth), .chReq(chReq), .chSel(chSel),
    .chUseFreq(chUseFreq), .chValue(chValue), .chDuty(chDuty),
    .chPolNeg(chPolNeg), .chIrqEn(chIrqEn), .chPrio(chPrio),
    .busy(busy), .cfgErr(cfgErr), .timerPowered(timerPowered),
    .chanEvent(chanEvent), .chanMatch(chanMatch), .irqValid(irqValid),
    .irqChan(irqChan), .irqPrio(irqPrio), .irqMatch(irqMatch),
    .pwmPin(pwmPin), .pwmPinEn(pwmPinEn)
  );
  dtp_pin_load pin_u (
    .sys_clk(sys_clk), .pwmPin(pwmPin), .pwmPinEn(pwmPinEn),
    .padLevel(padLevel)
  );

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc++;
    for (int i = 0; i < 8; i++) begin
      evCnt[i] += chanEvent[i];
      mtCnt[i] += chanMatch[i];
    end
    for (int i = 0; i < 5; i++) hiCnt[i] += padLevel[i];
    if (chanEvent[0] === 1'b1) begin
      gap0 = cyc - lastEv0;
      lastEv0 = cyc;
    end
    if (irqValid === 1'b1) begin
      lastPrio = irqPrio;
      lastChan = irqChan;
      lastKind = irqMatch;
    end
    if (cfgErr === 1'b1) errSeen = 1'b1;
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task automatic tcmd(input logic de, input logic [1:0] t, m,
                      input logic [5:0] w);
    @(negedge sys_clk);
    errSeen = 1'b0;
    cmdTimer = t;
    initMode = m;
    initWidth = w;
    initReq = ~de;
    deinitReq = de;
    @(negedge sys_clk);
    initReq = 1'b0;
    deinitReq = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  // the command pulse is one cycle; completion is busy falling again
  task automatic ccfg(input logic [1:0] t, s, input logic f,
                      input logic [31:0] v, input logic [13:0] d,
                      input logic p, input logic [2:0] pr);
    int n;
    @(negedge sys_clk);
    errSeen = 1'b0;
    cmdTimer = t;
    chSel = s;
    chUseFreq = f;
    chValue = v;
    chDuty = d;
    chPolNeg = p;
    chPrio = pr;
    chReq = 1'b1;
    @(negedge sys_clk);
    chReq = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk("busy", 32'h0, {31'h0, busy});
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic span(input int n);
    evCnt = '{default: 0};
    mtCnt = '{default: 0};
    hiCnt = '{default: 0};
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic final_report;
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    final_report;
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    chk("pin enable", 32'h0, {27'h0, pwmPinEn});
    for (int i = 0; i < 3; i++) begin
      tcmd(1'b0, 2'h0, badM[i], badW[i]);
      chk("bad init", 32'h1, {31'h0, errSeen});
    end
    chk("powered", 32'h0, {28'h0, timerPowered});
    ccfg(2'h0, 2'h1, 1'b0, 32'd2, 14'h0, 1'b0, 3'h1);
    chk("cold channel", 32'h1, {31'h0, errSeen});
    tcmd(1'b0, 2'h0, 2'h1, 6'd16);
    tcmd(1'b0, 2'h1, 2'h0, 6'd32);
    tcmd(1'b0, 2'h2, 2'h2, 6'd16);
    tcmd(1'b0, 2'h3, 2'h2, 6'd16);
    chk("powered", 32'hf, {28'h0, timerPowered});
    ccfg(2'h0, 2'h3, 1'b0, 32'd2, 14'h0, 1'b0, 3'h1);
    chk("narrow pair", 32'h1, {31'h0, errSeen});
    ccfg(2'h1, 2'h1, 1'b0, 32'd2, 14'h0, 1'b0, 3'h1);
    chk("wide single", 32'h1, {31'h0, errSeen});
    ccfg(2'h0, 2'h1, 1'b0, 32'd2, 14'h0, 1'b0, 3'h5);
    ccfg(2'h0, 2'h2, 1'b1, 32'd1000000, 14'h0, 1'b0, 3'h7);
    span(1000);
    chk("periodic a", 32'd5, evCnt[0]);
    chk("freq b", 32'd10, evCnt[1]);
    chk("gap", 32'd200, gap0);
    chk("timeout kind", 32'h0, {31'h0, lastKind});
    tcmd(1'b1, 2'h0, 2'h0, 6'd16);
    chk("powered", 32'he, {28'h0, timerPowered});
    ccfg(2'h1, 2'h3, 1'b0, 32'd3, 14'h0, 1'b0, 3'h2);
    span(1000);
    chk("stopped", 32'h0, evCnt[0] + evCnt[1]);
    chk("one shot", 32'd1, evCnt[2]);
    chk("wide b", 32'h0, evCnt[3]);
    chk("prio", 32'd2, {29'h0, lastPrio});
    chk("irq chan", 32'd2, {29'h0, lastChan});
    for (int i = 0; i < 4; i++) begin
      ccfg(2'h2, 2'h2, 1'b1, 32'd1000000, dutyT[i], polT[i], 3'h4);
      span(200);
      span(1000);
      chk("pin level", hiT[i], hiCnt[2]);
      chk("match", mtT[i], mtCnt[5]);
      chk("event", mtT[i], evCnt[5]);
    end
    chk("match kind", 32'h1, {31'h0, lastKind});
    chk("pin enable", 32'h4, {27'h0, pwmPinEn});
    ccfg(2'h2, 2'h2, 1'b1, 32'd1000, 14'd0, 1'b0, 3'h4);
    chk("narrow long", 32'h1, {31'h0, errSeen});
    ccfg(2'h2, 2'h2, 1'b1, 32'd1000000, 14'd10001, 1'b0, 3'h4);
    chk("duty limit", 32'h1, {31'h0, errSeen});
    ccfg(2'h3, 2'h1, 1'b1, 32'd1000000, 14'd5000, 1'b0, 3'h1);
    ccfg(2'h3, 2'h2, 1'b1, 32'd1000000, 14'd2500, 1'b0, 3'h1);
    span(200);
    span(1000);
    chk("pin t3a", 32'd500, hiCnt[3]);
    chk("pin t3b", 32'd250, hiCnt[4]);
    chk("pin enable", 32'h1c, {27'h0, pwmPinEn});
    final_report;
  end
endmodule
